//--- ddw_params.svh
// offsets, field positions, reset values and fixed codes of the dual watchdog
// assumes inclusion by bare name from the watchdog design files
`ifndef DDW_PARAMS_SVH
`define DDW_PARAMS_SVH

// address pages of the two instances, haddr[31:12]
`define DDW_NS_PAGE 20'h40081
`define DDW_S_PAGE 20'h50081

// register offsets inside a 4 KB page
`define DDW_OFF_LOAD 12'h000
`define DDW_OFF_VALUE 12'h004
`define DDW_OFF_CTRL 12'h008
`define DDW_OFF_INTCLR 12'h00C
`define DDW_OFF_RIS 12'h010
`define DDW_OFF_MIS 12'h014
`define DDW_OFF_ROUTE 12'h020
`define DDW_OFF_LOCK 12'hC00
`define DDW_OFF_ITCR 12'hF00
`define DDW_OFF_ITOP 12'hF04
`define DDW_OFF_PID4 12'hFD0
`define DDW_OFF_PID0 12'hFE0
`define DDW_OFF_PID1 12'hFE4
`define DDW_OFF_PID2 12'hFE8
`define DDW_OFF_PID3 12'hFEC
`define DDW_OFF_CID0 12'hFF0
`define DDW_OFF_CID1 12'hFF4
`define DDW_OFF_CID2 12'hFF8
`define DDW_OFF_CID3 12'hFFC

// field positions
`define DDW_CTRL_INTEN 0
`define DDW_CTRL_RESEN 1
`define DDW_ITOP_RES 0
`define DDW_ITOP_INT 1
`define DDW_ROUTE_PERMIT 0

// reset values
`define DDW_LOAD_RST 32'hFFFFFFFF
`define DDW_CTRL_RST 2'h0
`define DDW_WORD_RST 32'h00000000

// unlock key, arbitrary value
`define DDW_UNLOCK_KEY 32'hC0DE5AFE

// identification codes, arbitrary values
`define DDW_ID_PID4 8'h31
`define DDW_ID_PID0 8'h32
`define DDW_ID_PID1 8'h33
`define DDW_ID_PID2 8'h34
`define DDW_ID_PID3 8'h35
`define DDW_ID_CID0 8'h36
`define DDW_ID_CID1 8'h37
`define DDW_ID_CID2 8'h38
`define DDW_ID_CID3 8'h39

`endif

//--- ddw_pkg.sv
// types shared by the dual watchdog design files
// assumes nothing beyond a SystemVerilog compiler
package ddw_pkg;
  // which of the two watchdog instances a bus access targets
  typedef enum logic [0:0] {
    DDW_BANK_NS,
    DDW_BANK_S
  } ddw_bank_type;

  typedef logic [31:0] ddw_word_type;
endpackage

//--- ddw_counter.sv
// one watchdog down-counter with its raw interrupt and reset request
// assumes load and clear strobes are single cycles from the register file
`timescale 1ns/10ps
`default_nettype none
`include "ddw_params.svh"

module ddw_counter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic halt,
  input wire logic countEnable,
  input wire logic loadWrite,
  input wire ddw_pkg::ddw_word_type loadData,
  input wire ddw_pkg::ddw_word_type reloadValue,
  input wire logic clearWrite,
  output ddw_pkg::ddw_word_type count,
  output logic rawInt,
  output logic resetReq
);
  logic expiry;

  // zero reached while running, and no load write pre-empting it
  assign expiry = countEnable && !halt && !loadWrite && (count == 32'h00000000);

  // down-counter, restarted by load writes and interrupt clears
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= `DDW_LOAD_RST;
    end else if (loadWrite) begin
      count <= loadData;
    end else if (clearWrite || expiry) begin
      count <= reloadValue;
    end else if (countEnable && !halt) begin
      count <= count - 32'h00000001;
    end
  end

  // sticky raw interrupt, expiry wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rawInt <= 1'b0;
    end else if (expiry) begin
      rawInt <= 1'b1;
    end else if (clearWrite) begin
      rawInt <= 1'b0;
    end
  end

  // second expiry with the interrupt still pending asks for reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resetReq <= 1'b0;
    end else if (expiry && rawInt) begin
      resetReq <= 1'b1;
    end else if (clearWrite) begin
      resetReq <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- ddw_ahb_port.sv
// AHB-Lite slave front end: one wait state on every transfer, OKAY always
// assumes it is the only slave, so hready is its own hreadyout
`timescale 1ns/10ps
`default_nettype none
`include "ddw_params.svh"

module ddw_ahb_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic regWrite,
  output logic regRead,
  output ddw_pkg::ddw_bank_type regBank,
  output logic [11:0] regOffset,
  output ddw_pkg::ddw_word_type regWdata,
  input wire ddw_pkg::ddw_word_type regRdata
);
  logic pend;
  logic capWrite;
  logic capWord;
  logic [31:0] capAddr;
  logic mapped;
  logic accept;

  assign accept = hsel && hready && htrans[1];
  assign mapped = (capAddr[31:12] == `DDW_NS_PAGE) || (capAddr[31:12] == `DDW_S_PAGE);
  assign regBank = (capAddr[31:12] == `DDW_S_PAGE) ? ddw_pkg::DDW_BANK_S : ddw_pkg::DDW_BANK_NS;
  assign regOffset = {capAddr[11:2], 2'b00};
  assign regWdata = hwdata;
  assign regWrite = pend && capWrite && capWord && mapped;
  assign regRead = pend && !capWrite && mapped;

  // address phase capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
      capWrite <= 1'b0;
      capWord <= 1'b0;
      capAddr <= 32'h00000000;
    end else if (accept) begin
      pend <= 1'b1;
      capWrite <= hwrite;
      capWord <= (hsize == 3'h2);
      capAddr <= haddr;
    end else begin
      pend <= 1'b0;
    end
  end

  // one wait state, then read data and ready together
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else if (accept) begin
      hreadyout <= 1'b0;
    end else if (pend) begin
      hreadyout <= 1'b1;
      hrdata <= regRead ? regRdata : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

//--- ddw_top.sv
// dual watchdog: non-secure and secure instances behind one AHB-Lite port
// assumes rst is the warm system reset, and halt comes from another domain
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ddw_params.svh"

module ddw_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic debugCrossTriggerHalt,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [1:0] nsWdogIrq,
  output logic [1:0] secWdogNmi,
  output logic nsResetIrq,
  output logic sysResetReq
);
  // bus side of the register file
  logic regWrite;
  logic regRead;
  ddw_pkg::ddw_bank_type regBank;
  logic [11:0] regOffset;
  ddw_pkg::ddw_word_type regWdata;
  ddw_pkg::ddw_word_type regRdata;

  // halt synchroniser
  logic haltMeta;
  logic haltSync;

  // per-instance state, index 0 non-secure, index 1 secure
  ddw_pkg::ddw_word_type loadReg [2];
  logic [1:0] ctrlReg [2];
  ddw_pkg::ddw_word_type lockReg [2];
  logic itcrReg [2];
  logic [1:0] itopReg [2];
  ddw_pkg::ddw_word_type count [2];
  logic rawInt [2];
  logic resetReq [2];
  logic unlocked [2];
  logic bankWrite [2];
  logic loadWrite [2];
  logic clearWrite [2];
  logic intOut [2];
  logic resOut [2];

  // non-secure reset routing, set by software to permit direct reset
  logic routePermit;

  logic selS;

  ddw_ahb_port u_port (
    .ref_clk(ref_clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .regWrite(regWrite),
    .regRead(regRead),
    .regBank(regBank),
    .regOffset(regOffset),
    .regWdata(regWdata),
    .regRdata(regRdata)
  );

  // two flops before the halt level is used
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      haltMeta <= 1'b0;
      haltSync <= 1'b0;
    end else begin
      haltMeta <= debugCrossTriggerHalt;
      haltSync <= haltMeta;
    end
  end

  assign selS = (regBank == ddw_pkg::DDW_BANK_S);

  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_bank
      // a write reaches only the instance whose page was addressed
      assign bankWrite[b] = regWrite && (selS == (b == 1));
      assign unlocked[b] = (lockReg[b] == `DDW_UNLOCK_KEY);
      assign loadWrite[b] = bankWrite[b] && unlocked[b] && (regOffset == `DDW_OFF_LOAD);
      assign clearWrite[b] = bankWrite[b] && unlocked[b] && (regOffset == `DDW_OFF_INTCLR);

      // load register
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          loadReg[b] <= `DDW_LOAD_RST;
        end else if (loadWrite[b]) begin
          loadReg[b] <= regWdata;
        end
      end

      // control register, interrupt enable and reset enable
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          ctrlReg[b] <= `DDW_CTRL_RST;
        end else if (bankWrite[b] && unlocked[b] && (regOffset == `DDW_OFF_CTRL)) begin
          ctrlReg[b] <= regWdata[1:0];
        end
      end

      // lock register, always writable so that software can unlock
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          lockReg[b] <= `DDW_WORD_RST;
        end else if (bankWrite[b] && (regOffset == `DDW_OFF_LOCK)) begin
          lockReg[b] <= regWdata;
        end
      end

      // integration test mode and the test output values
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          itcrReg[b] <= 1'b0;
          itopReg[b] <= 2'h0;
        end else if (bankWrite[b] && unlocked[b]) begin
          if (regOffset == `DDW_OFF_ITCR) begin
            itcrReg[b] <= regWdata[0];
          end else if (regOffset == `DDW_OFF_ITOP) begin
            itopReg[b] <= regWdata[1:0];
          end
        end
      end

      ddw_counter u_counter (
        .ref_clk(ref_clk),
        .rst(rst),
        .halt(haltSync),
        .countEnable(ctrlReg[b][`DDW_CTRL_INTEN]),
        .loadWrite(loadWrite[b]),
        .loadData(regWdata),
        .reloadValue(loadReg[b]),
        .clearWrite(clearWrite[b]),
        .count(count[b]),
        .rawInt(rawInt[b]),
        .resetReq(resetReq[b])
      );

      // test mode takes the outputs over from the counter
      always_comb begin
        if (itcrReg[b]) begin
          intOut[b] = itopReg[b][`DDW_ITOP_INT];
          resOut[b] = itopReg[b][`DDW_ITOP_RES];
        end else begin
          intOut[b] = rawInt[b] && ctrlReg[b][`DDW_CTRL_INTEN];
          resOut[b] = resetReq[b] && ctrlReg[b][`DDW_CTRL_RESEN];
        end
      end
    end
  endgenerate

  // non-secure reset routing bit, guarded by the non-secure lock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      routePermit <= 1'b0;
    end else if (bankWrite[0] && unlocked[0] && (regOffset == `DDW_OFF_ROUTE)) begin
      routePermit <= regWdata[`DDW_ROUTE_PERMIT];
    end
  end

  // register read decode for the addressed instance
  always_comb begin
    int unsigned i;
    i = selS ? 1 : 0;
    regRdata = 32'h00000000;
    if (regOffset == `DDW_OFF_LOAD) begin
      regRdata = loadReg[i];
    end else if (regOffset == `DDW_OFF_VALUE) begin
      regRdata = count[i];
    end else if (regOffset == `DDW_OFF_CTRL) begin
      regRdata = {30'h0, ctrlReg[i]};
    end else if (regOffset == `DDW_OFF_RIS) begin
      regRdata = {31'h0, rawInt[i]};
    end else if (regOffset == `DDW_OFF_MIS) begin
      regRdata = {31'h0, rawInt[i] && ctrlReg[i][`DDW_CTRL_INTEN]};
    end else if (regOffset == `DDW_OFF_ROUTE && !selS) begin
      regRdata = {31'h0, routePermit};
    end else if (regOffset == `DDW_OFF_LOCK) begin
      regRdata = lockReg[i];
    end else if (regOffset == `DDW_OFF_ITCR) begin
      regRdata = {31'h0, itcrReg[i]};
    end else if (regOffset == `DDW_OFF_PID4) begin
      regRdata = {24'h000000, `DDW_ID_PID4};
    end else if (regOffset == `DDW_OFF_PID0) begin
      regRdata = {24'h000000, `DDW_ID_PID0};
    end else if (regOffset == `DDW_OFF_PID1) begin
      regRdata = {24'h000000, `DDW_ID_PID1};
    end else if (regOffset == `DDW_OFF_PID2) begin
      regRdata = {24'h000000, `DDW_ID_PID2};
    end else if (regOffset == `DDW_OFF_PID3) begin
      regRdata = {24'h000000, `DDW_ID_PID3};
    end else if (regOffset == `DDW_OFF_CID0) begin
      regRdata = {24'h000000, `DDW_ID_CID0};
    end else if (regOffset == `DDW_OFF_CID1) begin
      regRdata = {24'h000000, `DDW_ID_CID1};
    end else if (regOffset == `DDW_OFF_CID2) begin
      regRdata = {24'h000000, `DDW_ID_CID2};
    end else if (regOffset == `DDW_OFF_CID3) begin
      regRdata = {24'h000000, `DDW_ID_CID3};
    end
  end

  // registered interrupt and reset outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nsWdogIrq <= 2'h0;
      secWdogNmi <= 2'h0;
      nsResetIrq <= 1'b0;
      sysResetReq <= 1'b0;
    end else begin
      nsWdogIrq <= {2{intOut[0]}};
      secWdogNmi <= {2{intOut[1]}};
      nsResetIrq <= resOut[0] && !routePermit;
      sysResetReq <= resOut[1] || (resOut[0] && routePermit);
    end
  end
endmodule
`default_nettype wire

//--- ddw_top_chk.sv
// assertions on the dual watchdog top-level ports
// assumes it is bound to ddw_top and that rst is the only reset
`timescale 1ns/10ps
`default_nettype none
module ddw_top_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic debugCrossTriggerHalt,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [1:0] nsWdogIrq,
  input wire logic [1:0] secWdogNmi,
  input wire logic nsResetIrq,
  input wire logic sysResetReq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic take;
  // address phase accepted at this edge
  assign take = hsel && hready && htrans[1];
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("error response seen");
  AST_WAIT: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  AST_IDLE: assert property (hreadyout && !take |=> hreadyout)
    else $error("wait state without transfer");
  AST_RDHOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed while idle");
  AST_IRQPAIR: assert property (nsWdogIrq[0] == nsWdogIrq[1])
    else $error("cores see different interrupts");
  AST_NMIPAIR: assert property (secWdogNmi[0] == secWdogNmi[1])
    else $error("cores see different nmi");
  AST_HALT: assert property ((debugCrossTriggerHalt && !take) [*8]
    |-> $stable(nsWdogIrq) && $stable(secWdogNmi))
    else $error("outputs moved while halted");
  AST_NSRES: assert property ($rose(nsResetIrq) |-> nsWdogIrq[0])
    else $error("reset irq without pending interrupt");
  AST_SYSRES: assert property ($rose(sysResetReq) |-> nsWdogIrq[0] || secWdogNmi[0])
    else $error("system reset without pending interrupt");
  // main scenarios reached
  COV_NMI: cover property ($rose(secWdogNmi[0]));
  COV_NSRES: cover property ($rose(nsResetIrq));
  COV_SYSRES: cover property ($rose(sysResetReq));
endmodule
`default_nettype wire

//--- ddw_sys_model.sv
// model of the system reset logic facing the watchdog outputs
// assumes reset requests are levels that drop once the system is reset
`timescale 1ns/10ps
`default_nettype none
module ddw_sys_model (
  input wire logic ref_clk,
  input wire logic sysResetReq,
  output logic sysRst,
  output int resetCount
);
  logic [2:0] hold = 3'h0;
  int cnt = 0;
  // a request holds the warm system reset for four cycles
  always_ff @(posedge ref_clk) begin
    if (sysResetReq && hold == 3'h0) begin
      hold <= 3'h4;
      cnt <= cnt + 1;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign sysRst = hold != 3'h0;
  assign resetCount = cnt;
endmodule
`default_nettype wire

//--- test_dual_domain_watchdog.sv
// self-checking bench for the dual watchdog over AHB-Lite
// assumes ddw_top is the only slave and the system model drives reset
`timescale 1ns/10ps
`default_nettype none
`include "ddw_params.svh"
module test_dual_domain_watchdog;
  localparam logic [19:0] NSP = 20'h40081;
  localparam logic [19:0] SEP = 20'h50081;
  logic ref_clk = 1'b0;
  logic benchRst = 1'b1;
  logic halt = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic [31:0] v1;
  logic hreadyout;
  logic hresp;
  logic nsResetIrq;
  logic sysResetReq;
  logic sysRst;
  logic rst;
  logic [1:0] nsWdogIrq;
  logic [1:0] secWdogNmi;
  int resetCount;
  int errTotal = 0;
  int samplesChecked = 0;
  logic [11:0] rOff [8] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'hC00, 12'hF00, 12'h00C};
  logic [31:0] rVal [8] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  assign rst = benchRst | sysRst;
  always #12.5 ref_clk = ~ref_clk;
  ddw_top u_dut (.ref_clk(ref_clk), .rst(rst), .debugCrossTriggerHalt(halt), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .nsWdogIrq(nsWdogIrq), .secWdogNmi(secWdogNmi), .nsResetIrq(nsResetIrq),
    .sysResetReq(sysResetReq));
  ddw_sys_model u_sys (.ref_clk(ref_clk), .sysResetReq(sysResetReq), .sysRst(sysRst),
    .resetCount(resetCount));
  // verdict and end of run
  task automatic final_report;
    if (errTotal == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait for hready high at an edge
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      errTotal++;
      final_report;
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask
  function automatic logic sigv(input int k);
    case (k)
      0: return nsWdogIrq[0];
      1: return nsResetIrq;
      2: return secWdogNmi[0];
      3: return rst;
      default: return !rst;
    endcase
  endfunction
  // bounded wait for one watched signal
  task automatic waitfor(input int k);
    int n;
    for (n = 0; n < 600 && sigv(k) !== 1'b1; n++) @(posedge ref_clk);
    if (sigv(k) !== 1'b1) begin
      errTotal++;
      final_report;
    end
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    benchRst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) rc("reset value", {NSP, rOff[i]}, rVal[i]);
    wr({NSP, 12'h000}, 32'h5);
    rc("locked load", {NSP, 12'h000}, 32'hFFFFFFFF);
    rc("unmapped", 32'h40082000, 32'h0);
    wr({NSP, 12'hC00}, `DDW_UNLOCK_KEY);
    rc("lock", {NSP, 12'hC00}, `DDW_UNLOCK_KEY);
    wr({NSP, 12'h008}, 32'h00000002);
    rc("control", {NSP, 12'h008}, 32'h2);
    wr({NSP, 12'h000}, 32'hA);
    rc("restart", {NSP, 12'h004}, 32'hA);
    wr({NSP, 12'h008}, 32'h3);
    waitfor(0);
    rc("raw", {NSP, 12'h010}, 32'h1);
    rc("masked", {NSP, 12'h014}, 32'h1);
    waitfor(1);
    chk("direct reset", {31'h0, sysResetReq}, 32'h0);
    wr({NSP, 12'h00C}, 32'h1);
    rc("raw cleared", {NSP, 12'h010}, 32'h0);
    chk("reset irq cleared", {31'h0, nsResetIrq}, 32'h0);
    wr({NSP, 12'h000}, 32'hC8);
    halt <= 1'b1;
    repeat (5) @(posedge ref_clk);
    xfer(1'b0, {NSP, 12'h004}, 32'h0, v1);
    repeat (20) @(posedge ref_clk);
    rc("halted count", {NSP, 12'h004}, v1);
    halt <= 1'b0;
    wr({NSP, 12'h008}, 32'h0);
    wr({NSP, 12'hF00}, 32'h1);
    wr({NSP, 12'hF04}, 32'h3);
    @(posedge ref_clk);
    chk("test irq", {30'h0, nsWdogIrq}, 32'h3);
    chk("test reset", {31'h0, nsResetIrq}, 32'h1);
    wr({NSP, 12'hF04}, 32'h0);
    wr({NSP, 12'hF00}, 32'h0);
    wr({NSP, 12'h020}, 32'h1);
    wr({NSP, 12'h000}, 32'h5);
    wr({NSP, 12'h008}, 32'h3);
    waitfor(3);
    waitfor(4);
    chk("system resets", resetCount, 32'h1);
    rc("lock after reset", {NSP, 12'hC00}, 32'h0);
    rc("route after reset", {NSP, 12'h020}, 32'h0);
    wr({SEP, 12'hC00}, `DDW_UNLOCK_KEY);
    wr({SEP, 12'h000}, 32'h3);
    wr({SEP, 12'h008}, 32'h3);
    waitfor(2);
    chk("nmi both cores", {30'h0, secWdogNmi}, 32'h3);
    chk("ns irq quiet", {30'h0, nsWdogIrq}, 32'h0);
    waitfor(3);
    waitfor(4);
    chk("secure reset", resetCount, 32'h2);
    for (int i = 0; i < 9; i++) rc("ident", {NSP, (i == 0) ? 12'hFD0 : 12'hFDC + 12'(4 * i)},
      {24'h0, 8'(`DDW_ID_PID4 + i)});
    final_report;
  end
endmodule
bind ddw_top ddw_top_chk u_chk (.ref_clk(ref_clk), .rst(rst),
  .debugCrossTriggerHalt(debugCrossTriggerHalt), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .nsWdogIrq(nsWdogIrq), .secWdogNmi(secWdogNmi), .nsResetIrq(nsResetIrq),
  .sysResetReq(sysResetReq));
`default_nettype wire
